// *** rtl/usbxc_pkg.sv ***
// Constants for the USB transceiver control block
package usbxc_pkg;
  localparam logic [7:0] XCN_ADDR       = 8'hd7;
  localparam logic [7:0] XCN_RESET      = 8'h00;
  localparam int         PULLUP_EN_BIT  = 7;
  localparam int         XCVR_EN_BIT    = 6;
  localparam int         SPEED_BIT      = 5;
  localparam int         TEST_HI_BIT    = 4;
  localparam int         TEST_LO_BIT    = 3;
  localparam int         DIFF_BIT       = 2;
  localparam int         DPLUS_BIT      = 1;
  localparam int         DMINUS_BIT     = 0;
  localparam logic [7:0] WRITABLE_MASK  = 8'hf8;
  localparam int         EP_PAIRS       = 3;
  localparam logic [7:0] EP_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] EP_IN_FLAG     = 8'h80;
  typedef enum logic [1:0] {
    USBXC_TEST_NORMAL = 2'h0,
    USBXC_TEST_DIFF1  = 2'h1,
    USBXC_TEST_DIFF0  = 2'h2,
    USBXC_TEST_SE0    = 2'h3
  } usbxc_test_type;
endpackage

// *** rtl/usbxc_transceiver_control.sv ***
// USB function transceiver control register and line drive
// What this block does
// - Acts as USB function only, never host
// - Endpoint zero is control, address 0x00
// - Three IN/OUT pairs, addresses 0x81-0x83, 0x01-0x03
// - Speed one: full speed, pull-up on D+
// - Speed zero: low speed, pull-up on D-
// - Pull-up enable bit attaches or detaches device
// - Pull-up only while VBUS is present
// - Transceiver enable bit; zero means suspend
// - Test field forces line drive states while transceiver enable is set
// - Bit 2 reports differential receiver value
`timescale 1ns/10ps
`default_nettype none
module usbxc_transceiver_control (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic       vbusPresent,
  input  wire logic       dplusIn,
  input  wire logic       dminusIn,
  output logic            dplusOut,
  output logic            dplusOe,
  output logic            dminusOut,
  output logic            dminusOe,
  output logic            dplusPullup,
  output logic            dminusPullup,
  output logic            transceiverSuspend,
  output logic            fullSpeed,
  output logic            hostRole,
  output logic [7:0]      epInAddr1,
  output logic [7:0]      epInAddr3,
  output logic [7:0]      epOutAddr3,
  output logic [7:0]      epCtrlAddr
);
  logic [7:0] ctrl_q;
  logic [1:0] vbusSync_q, dpSync_q, dmSync_q;
  logic       vbus, dpLevel, dmLevel;
  logic       wrHit;

  // Two-stage synchronisers; only stage 2 is read
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      vbusSync_q <= 2'h0;
      dpSync_q   <= 2'h0;
      dmSync_q   <= 2'h0;
    end else begin
      vbusSync_q <= {vbusSync_q[0], vbusPresent};
      dpSync_q   <= {dpSync_q[0], dplusIn};
      dmSync_q   <= {dmSync_q[0], dminusIn};
    end
  end
  assign vbus    = vbusSync_q[1];
  assign dpLevel = dpSync_q[1];
  assign dmLevel = dmSync_q[1];

  assign wrHit = regWr && (regAddr == usbxc_pkg::XCN_ADDR);

  // Only bits 7..3 store; status bits stay zero here
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= usbxc_pkg::XCN_RESET;
    end else if (wrHit) begin
      ctrl_q <= regWdata & usbxc_pkg::WRITABLE_MASK;
    end
  end

  logic pullupEn, xcvrEn, speed;
  assign pullupEn = ctrl_q[usbxc_pkg::PULLUP_EN_BIT];
  assign xcvrEn   = ctrl_q[usbxc_pkg::XCVR_EN_BIT];
  assign speed    = ctrl_q[usbxc_pkg::SPEED_BIT];
  usbxc_pkg::usbxc_test_type testMode;
  assign testMode = usbxc_pkg::usbxc_test_type'(
    ctrl_q[usbxc_pkg::TEST_HI_BIT:usbxc_pkg::TEST_LO_BIT]);

  // Readback with live line status
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= usbxc_pkg::XCN_RESET;
    end else if (regAddr == usbxc_pkg::XCN_ADDR) begin
      regRdata <= ctrl_q;
      regRdata[usbxc_pkg::DIFF_BIT]   <= xcvrEn & dpLevel & ~dmLevel;
      regRdata[usbxc_pkg::DPLUS_BIT]  <= dpLevel;
      regRdata[usbxc_pkg::DMINUS_BIT] <= dmLevel;
    end else begin
      regRdata <= 8'h00;
    end
  end

  // Pull-up placement
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dplusPullup  <= 1'b0;
      dminusPullup <= 1'b0;
      fullSpeed    <= 1'b0;
    end else begin
      dplusPullup  <= pullupEn & vbus & speed;
      dminusPullup <= pullupEn & vbus & ~speed;
      fullSpeed    <= speed;
    end
  end

  // Test-mode line drive
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dplusOut           <= 1'b0;
      dminusOut          <= 1'b0;
      dplusOe            <= 1'b0;
      dminusOe           <= 1'b0;
      transceiverSuspend <= 1'b1;
    end else begin
      transceiverSuspend <= ~xcvrEn;
      dplusOe  <= xcvrEn && (testMode != usbxc_pkg::USBXC_TEST_NORMAL);
      dminusOe <= xcvrEn && (testMode != usbxc_pkg::USBXC_TEST_NORMAL);
      unique case (testMode)
        usbxc_pkg::USBXC_TEST_NORMAL: begin
          dplusOut  <= 1'b0;
          dminusOut <= 1'b0;
        end
        usbxc_pkg::USBXC_TEST_DIFF1: begin
          dplusOut  <= 1'b1;
          dminusOut <= 1'b0;
        end
        usbxc_pkg::USBXC_TEST_DIFF0: begin
          dplusOut  <= 1'b0;
          dminusOut <= 1'b1;
        end
        usbxc_pkg::USBXC_TEST_SE0: begin
          dplusOut  <= 1'b0;
          dminusOut <= 1'b0;
        end
      endcase
    end
  end

  // Fixed function role and endpoint map
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hostRole   <= 1'b0;
      epCtrlAddr <= usbxc_pkg::EP_CTRL_ADDR;
      epInAddr1  <= usbxc_pkg::EP_IN_FLAG | 8'h01;
      epInAddr3  <= usbxc_pkg::EP_IN_FLAG | 8'(usbxc_pkg::EP_PAIRS);
      epOutAddr3 <= 8'(usbxc_pkg::EP_PAIRS);
    end else begin
      hostRole   <= 1'b0;
      epCtrlAddr <= usbxc_pkg::EP_CTRL_ADDR;
      epInAddr1  <= usbxc_pkg::EP_IN_FLAG | 8'h01;
      epInAddr3  <= usbxc_pkg::EP_IN_FLAG | 8'(usbxc_pkg::EP_PAIRS);
      epOutAddr3 <= 8'(usbxc_pkg::EP_PAIRS);
    end
  end

  property p_pullup_dplus;
    @(posedge mclk) disable iff (!nrst)
    (pullupEn && vbus && speed) |=> dplusPullup && !dminusPullup;
  endproperty
  a_pullup_dplus: assert property (p_pullup_dplus) else $error("D+ pull-up missing");

  property p_pullup_dminus;
    @(posedge mclk) disable iff (!nrst)
    (pullupEn && vbus && !speed) |=> dminusPullup && !dplusPullup;
  endproperty
  a_pullup_dminus: assert property (p_pullup_dminus) else $error("D- pull-up missing");

  property p_detached;
    @(posedge mclk) disable iff (!nrst)
    !pullupEn |=> !dplusPullup && !dminusPullup;
  endproperty
  a_detached: assert property (p_detached) else $error("Pull-up on while disabled");

  property p_vbus_gate;
    @(posedge mclk) disable iff (!nrst)
    (dplusPullup || dminusPullup) |-> $past(vbus);
  endproperty
  a_vbus_gate: assert property (p_vbus_gate) else $error("Pull-up without VBUS");

  property p_suspend;
    @(posedge mclk) disable iff (!nrst)
    wrHit ##1 1'b1 |=> transceiverSuspend == !$past(regWdata[usbxc_pkg::XCVR_EN_BIT], 2);
  endproperty
  a_suspend: assert property (p_suspend) else $error("Suspend not following enable");

  property p_se0;
    @(posedge mclk) disable iff (!nrst)
    (xcvrEn && testMode == usbxc_pkg::USBXC_TEST_SE0) |=> dplusOe && !dplusOut && !dminusOut;
  endproperty
  a_se0: assert property (p_se0) else $error("SE0 not driven");

  property p_diff_read;
    @(posedge mclk) disable iff (!nrst)
    (regAddr == usbxc_pkg::XCN_ADDR && !xcvrEn) |=> !regRdata[usbxc_pkg::DIFF_BIT];
  endproperty
  a_diff_read: assert property (p_diff_read) else $error("Receiver bit set while disabled");

  property p_live_lines;
    @(posedge mclk) disable iff (!nrst)
    regAddr == usbxc_pkg::XCN_ADDR |=>
      regRdata[usbxc_pkg::DPLUS_BIT] == $past(dpLevel) &&
      regRdata[usbxc_pkg::DMINUS_BIT] == $past(dmLevel);
  endproperty
  a_live_lines: assert property (p_live_lines) else $error("Line level readback wrong");

  property p_status_ro;
    @(posedge mclk) disable iff (!nrst)
    ctrl_q[2:0] == 3'h0;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("Status bits stored a write");

  property p_no_host;
    @(posedge mclk) disable iff (!nrst)
    !hostRole;
  endproperty
  a_no_host: assert property (p_no_host) else $error("Host role asserted");

  property p_diff1_drive;
    @(posedge mclk) disable iff (!nrst)
    (xcvrEn && testMode == usbxc_pkg::USBXC_TEST_DIFF1) |=>
      dplusOe && dminusOe && dplusOut && !dminusOut;
  endproperty
  a_diff1_drive: assert property (p_diff1_drive) else $error("Diff one wrong");

  property p_diff0_drive;
    @(posedge mclk) disable iff (!nrst)
    (xcvrEn && testMode == usbxc_pkg::USBXC_TEST_DIFF0) |=>
      dplusOe && dminusOe && !dplusOut && dminusOut;
  endproperty
  a_diff0_drive: assert property (p_diff0_drive) else $error("Diff zero wrong");

  property p_se0_dminus;
    @(posedge mclk) disable iff (!nrst)
    (xcvrEn && testMode == usbxc_pkg::USBXC_TEST_SE0) |=> dminusOe;
  endproperty
  a_se0_dminus: assert property (p_se0_dminus) else $error("SE0 D- not driven");

  property p_normal_release;
    @(posedge mclk) disable iff (!nrst)
    (!xcvrEn || testMode == usbxc_pkg::USBXC_TEST_NORMAL) |=> !dplusOe && !dminusOe;
  endproperty
  a_normal_release: assert property (p_normal_release) else $error("Lines driven");

  property p_full_speed;
    @(posedge mclk) disable iff (!nrst)
    speed |=> fullSpeed;
  endproperty
  a_full_speed: assert property (p_full_speed) else $error("Full speed not set");

  property p_low_speed;
    @(posedge mclk) disable iff (!nrst)
    !speed |=> !fullSpeed;
  endproperty
  a_low_speed: assert property (p_low_speed) else $error("Low speed not set");

  property p_one_pullup;
    @(posedge mclk) disable iff (!nrst)
    !(dplusPullup && dminusPullup);
  endproperty
  a_one_pullup: assert property (p_one_pullup) else $error("Both pull-ups on");

  property p_vbus_off;
    @(posedge mclk) disable iff (!nrst)
    !vbus |=> !dplusPullup && !dminusPullup;
  endproperty
  a_vbus_off: assert property (p_vbus_off) else $error("Pull-up with VBUS off");

  property p_enable_awake;
    @(posedge mclk) disable iff (!nrst)
    xcvrEn |=> !transceiverSuspend;
  endproperty
  a_enable_awake: assert property (p_enable_awake) else $error("Suspend while on");

  property p_ctrl_write;
    @(posedge mclk) disable iff (!nrst)
    wrHit |=> ctrl_q[7:3] == $past(regWdata[7:3]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("Write not stored");

  property p_ctrl_hold;
    @(posedge mclk) disable iff (!nrst)
    !wrHit |=> $stable(ctrl_q);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("Control changed");

  property p_diff_one;
    @(posedge mclk) disable iff (!nrst)
    (regAddr == usbxc_pkg::XCN_ADDR && xcvrEn && dpLevel && !dmLevel) |=>
      regRdata[usbxc_pkg::DIFF_BIT];
  endproperty
  a_diff_one: assert property (p_diff_one) else $error("Diff one not read");

  property p_diff_zero;
    @(posedge mclk) disable iff (!nrst)
    (regAddr == usbxc_pkg::XCN_ADDR && xcvrEn && !dpLevel && dmLevel) |=>
      !regRdata[usbxc_pkg::DIFF_BIT];
  endproperty
  a_diff_zero: assert property (p_diff_zero) else $error("Diff zero not read");

  property p_other_addr;
    @(posedge mclk) disable iff (!nrst)
    regAddr != usbxc_pkg::XCN_ADDR |=> regRdata == 8'h00;
  endproperty
  a_other_addr: assert property (p_other_addr) else $error("Other address read");

  property p_ctrl_ep;
    @(posedge mclk) disable iff (!nrst)
    epCtrlAddr == usbxc_pkg::EP_CTRL_ADDR;
  endproperty
  a_ctrl_ep: assert property (p_ctrl_ep) else $error("Control endpoint moved");
endmodule
`default_nettype wire

// *** testbench/usbxc_host_model.sv ***
// Host side of the USB lines: line resolution with host pull-downs
`timescale 1ns/10ps
`default_nettype none
module usbxc_host_model (
  input  wire logic vbusOn,
  input  wire logic hostDrv,
  input  wire logic hostDp,
  input  wire logic hostDm,
  input  wire logic dpOut,
  input  wire logic dpOe,
  input  wire logic dmOut,
  input  wire logic dmOe,
  input  wire logic dpPu,
  input  wire logic dmPu,
  output logic      vbus,
  output logic      dpLine,
  output logic      dmLine
);
  // Device drive wins, then host drive, then pull-up over pull-down
  assign vbus   = vbusOn;
  assign dpLine = dpOe ? dpOut : (hostDrv ? hostDp : dpPu);
  assign dmLine = dmOe ? dmOut : (hostDrv ? hostDm : dmPu);
endmodule
`default_nettype wire

// *** testbench/test_usb_function_transceiver_control.sv ***
// Self-checking bench of the USB transceiver control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_usb_function_transceiver_control;
  logic       mclk = 0, nrst = 0, regWr = 0, vbusOn = 0, hostDrv = 0, hostDp = 0, hostDm = 0;
  logic [7:0] regAddr = 8'hd7, regWdata = 8'h00, regRdata, epIn1, epIn3, epOut3, epCtrl;
  logic       vbus, dpLine, dmLine, dpOut, dpOe, dmOut, dmOe, dpPu, dmPu, susp, fs, host;
  int         fail_count = 0, n_tests = 0, cyc = 0;
  always #2 mclk = ~mclk;
  usbxc_transceiver_control usbxc_transceiver_control_i (.mclk(mclk), .nrst(nrst),
    .regAddr(regAddr), .regWr(regWr), .regWdata(regWdata), .regRdata(regRdata),
    .vbusPresent(vbus), .dplusIn(dpLine), .dminusIn(dmLine), .dplusOut(dpOut),
    .dplusOe(dpOe), .dminusOut(dmOut), .dminusOe(dmOe), .dplusPullup(dpPu),
    .dminusPullup(dmPu), .transceiverSuspend(susp), .fullSpeed(fs), .hostRole(host),
    .epInAddr1(epIn1), .epInAddr3(epIn3), .epOutAddr3(epOut3), .epCtrlAddr(epCtrl));
  usbxc_host_model usbxc_host_model_i (.vbusOn(vbusOn), .hostDrv(hostDrv), .hostDp(hostDp),
    .hostDm(hostDm), .dpOut(dpOut), .dpOe(dpOe), .dmOut(dmOut), .dmOe(dmOe), .dpPu(dpPu),
    .dmPu(dmPu), .vbus(vbus), .dpLine(dpLine), .dmLine(dmLine));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWr <= 1'b1;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
    regAddr <= 8'hd7;
    repeat (5) @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("regRdata", e, regRdata)
    regAddr <= 8'hd7;
  endtask
  task automatic t_reset();
    rd(8'hd7, 8'h00);
    `CHK("suspend", 1'b1, susp)
    `CHK("pullups", 2'b00, {dpPu, dmPu})
    `CHK("hostRole", 1'b0, host)
    `CHK("epCtrl", 8'h00, epCtrl)
    `CHK("epIn", 16'h8183, {epIn1, epIn3})
    `CHK("epOut3", 8'h03, epOut3)
    $display("done t_reset");
  endtask
  task automatic t_speed();
    vbusOn <= 1'b1;
    wr(8'hd7, 8'ha0);
    `CHK("fs pullup", 3'b110, {fs, dpPu, dmPu})
    rd(8'hd7, 8'ha2);
    wr(8'hd7, 8'h80);
    `CHK("ls pullup", 3'b001, {fs, dpPu, dmPu})
    rd(8'hd7, 8'h81);
    vbusOn <= 1'b0;
    wr(8'hd7, 8'ha0);
    `CHK("no vbus", 2'b00, {dpPu, dmPu})
    vbusOn <= 1'b1;
    wr(8'hd7, 8'h20);
    `CHK("detached", 2'b00, {dpPu, dmPu})
    $display("done t_speed");
  endtask
  task automatic t_test();
    logic [1:0] dr;
    for (int m = 0; m < 4; m++) begin
      dr = (m == 1) ? 2'b10 : (m == 2) ? 2'b01 : 2'b00;
      wr(8'hd7, 8'h60 | 8'(m << 3));
      `CHK("suspend", 1'b0, susp)
      if (m != 0) begin
        `CHK("drive", {2'b11, dr}, {dpOe, dmOe, dpOut, dmOut})
        rd(8'hd7, 8'h60 | 8'(m << 3) | {5'h00, dr[1] & ~dr[0], dr});
      end else begin
        `CHK("no drive", 2'b00, {dpOe, dmOe})
      end
    end
    $display("done t_test");
  endtask
  task automatic t_rx();
    hostDrv <= 1'b1;
    hostDp <= 1'b1;
    wr(8'hd7, 8'h07);
    rd(8'hd7, 8'h02);
    wr(8'hd7, 8'h40);
    rd(8'hd7, 8'h46);
    hostDp <= 1'b0;
    hostDm <= 1'b1;
    wr(8'h10, 8'hff);
    rd(8'hd7, 8'h41);
    rd(8'h10, 8'h00);
    wr(8'hd7, 8'hff);
    rd(8'hd7, 8'hf8);
    $display("done t_rx");
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_speed();
    t_test();
    t_rx();
    stop_test();
  end
endmodule
`default_nettype wire
